// *** rtl/ptrc_pkg.sv ***
/*
 Shared constants for the paper tape reader control block.
 Assumes a 10 MHz system clock; all cycle counts derive from it.
*/
package ptrc_pkg;
	// Clock period and documented times, each in its own unit
	localparam int CLK_PERIOD_NS = 100;
	localparam int START_DELAY_NS = 1000;
	localparam int SLOW_STEP_US = 5000;
	localparam int FAST_STEP_US = 1670;
	// Cycle counts; least time rounds up, intervals round down
	localparam int START_DELAY_CYC =
		(START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_STEP_CYC = SLOW_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int FAST_STEP_CYC = FAST_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int ACCEL_TICKS = 20; // Inside the 10 to 30 tick window
	localparam int STEP_CNT_W = 17;
	localparam int DLY_CNT_W = 4;
	// Buffer and tape geometry
	localparam int BUF_W = 18;
	localparam int CHAR_W = 6;
	localparam int LINE_W = 8;
	localparam int SLOT_W = 2;
	localparam int ENTRY_W = LINE_W + SLOT_W;
	localparam int FIFO_DEPTH = 4;
	// Low indices of the three binary characters and of the alnum line
	localparam int SEG_FIRST_LO = 12;
	localparam int SEG_SECOND_LO = 6;
	localparam int SEG_THIRD_LO = 0;
	localparam int SEG_ALNUM_LO = 0;
	// Where a line lands in the buffer, carried with each entry
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 2'h0;
	localparam logic [SLOT_W-1:0] SLOT_SECOND = 2'h1;
	localparam logic [SLOT_W-1:0] SLOT_THIRD = 2'h2;
	localparam logic [SLOT_W-1:0] SLOT_ALNUM = 2'h3;
	// Instruction low bits: index 0 is the last bit of the word
	localparam int IB_W = 6;
	localparam int IB_ALNUM_N = 5;
	localparam int IB_CLR_AC = 3;
	localparam int IB_SELECT = 2;
	localparam int IB_READ = 1;
	localparam int IB_SKIP = 0;
	// Step clock sequencer states
	typedef enum logic [1:0] {
		PTRC_IDLE = 2'b00,
		PTRC_START = 2'b01,
		PTRC_STEP = 2'b10
	} ptrc_seq_type;
endpackage

// *** rtl/ptrc_fifo_if.sv ***
/*
 Line carrier between the reader control and its line FIFO.
 Assumes both ends share one clock; flush empties the FIFO.
*/
`timescale 1ns/100ps
`default_nettype none
interface ptrc_fifo_if #(parameter int WIDTH = 10);
	logic push_valid; // Entry offered
	logic push_ready; // Room left
	logic [WIDTH-1:0] push_data; // Offered entry
	logic pop_valid; // Entry waiting
	logic pop_ready; // Drain accepts
	logic [WIDTH-1:0] pop_data; // Oldest entry
	logic flush; // Drop everything
	modport ctrl (output push_valid, push_data, pop_ready, flush,
		input push_ready, pop_valid, pop_data);
	modport store (input push_valid, push_data, pop_ready, flush,
		output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// *** rtl/ptrc_line_fifo.sv ***
/*
 Small line FIFO with valid/ready on both sides.
 Assumes one clock; flush wins over push and pop.
*/
`timescale 1ns/100ps
`default_nettype none
module ptrc_line_fifo
	import ptrc_pkg::*;
#(
	parameter int WIDTH = ENTRY_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	ptrc_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
		logic [AW-1:0] wr; // Write slot
		logic [AW-1:0] rd; // Read slot
		logic [AW:0] cnt; // Fill level
	} ptrc_fifo_type;

	ptrc_fifo_type st; // Current state
	ptrc_fifo_type next_st; // Next state
	logic do_push; // Write taken
	logic do_pop; // Read taken

	// Honest flags straight from the fill level
	assign port.push_ready = (st.cnt != FULL);
	assign port.pop_valid = (st.cnt != '0);
	assign port.pop_data = st.mem[st.rd];

	// Pointer and level update
	always_comb begin
		next_st = st;
		do_push = port.push_valid && port.push_ready;
		do_pop = port.pop_valid && port.pop_ready;
		if (do_push) begin
			next_st.mem[st.wr] = port.push_data;
			next_st.wr = (st.wr == LAST) ? '0 : st.wr + 1'b1;
		end
		if (do_pop) begin
			next_st.rd = (st.rd == LAST) ? '0 : st.rd + 1'b1;
		end
		// Both at once leaves the level unchanged
		if (do_push && !do_pop) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			next_st.cnt = st.cnt - 1'b1;
		end
		if (port.flush) begin
			next_st.wr = '0;
			next_st.rd = '0;
			next_st.cnt = '0;
		end
	end

	// State register
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// *** rtl/ptrc_reader_ctrl.sv ***
/*
 Paper tape reader control: instruction decode, start delay,
 accelerating step clock, two-bit stepper phase counter, line
 assembly into the 18-bit read buffer, flag and end of tape.
 Assumes the processor gives decoded device select, the six low
 instruction bits and the three execute pulses, all synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module ptrc_reader_ctrl
	import ptrc_pkg::*;
#(
	parameter int SLOW_CYC = SLOW_STEP_CYC, // Initial tick interval
	parameter int FAST_CYC = FAST_STEP_CYC, // Full-speed interval
	parameter int ACCEL_N = ACCEL_TICKS, // Ticks to reach speed
	parameter int LINE_FIFO_DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic device_select_in,
	input wire logic [IB_W-1:0] instr_bits_in,
	input wire logic first_exec_pulse_in,
	input wire logic second_exec_pulse_in,
	input wire logic third_exec_pulse_in,
	input wire logic [BUF_W-1:0] accumulator_in,
	input wire logic [LINE_W:1] hole_in,
	input wire logic feed_hole_in,
	input wire logic manual_feed_in,
	output logic [BUF_W-1:0] accumulator_out,
	output logic acc_load_out,
	output logic skip_request_out,
	output logic interrupt_request_out,
	output logic line_done_flag_out,
	output logic end_of_tape_out,
	output logic run_level_out,
	output logic step_clock_enable_out,
	output logic phase_bit_a_out,
	output logic phase_bit_b_out,
	output logic motor_power_out,
	output logic [3:0] winding_drive_out
);
	// Counter load values and the interval shrink per tick while accelerating
	localparam logic [STEP_CNT_W-1:0] SLOW_LD = STEP_CNT_W'(SLOW_CYC - 1);
	localparam logic [STEP_CNT_W-1:0] FAST_LD = STEP_CNT_W'(FAST_CYC - 1);
	localparam logic [STEP_CNT_W-1:0] ACCEL_DEC =
		STEP_CNT_W'((SLOW_CYC - FAST_CYC) / ACCEL_N);
	localparam logic [DLY_CNT_W-1:0] START_LD =
		DLY_CNT_W'(START_DELAY_CYC - 1);

	typedef struct packed {
		ptrc_seq_type seq; // Step clock sequencer
		logic [DLY_CNT_W-1:0] dly; // Start delay count
		logic [STEP_CNT_W-1:0] tick_cnt; // Cycles to next tick
		logic [STEP_CNT_W-1:0] interval; // Present tick interval
		logic run_flipflop; // Reader selected
		logic line_done_flag; // Word or line ready
		logic line_stage_one; // First line taken
		logic line_stage_two; // Second line taken
		logic alnum_mode_ff; // Alphanumeric selected
		logic end_of_tape_ff; // Tape ran out or tore
		logic phase_bit_a; // Phase counter high
		logic phase_bit_b; // Phase counter low
		logic motor_power_ff; // Windings enabled
		logic [LINE_W:1] sensed; // Holes under sensors
		logic count_due; // Count pulse falls next cycle
		logic push_valid; // Line offered to FIFO
		logic [ENTRY_W-1:0] push_data; // Line and its slot
		logic [BUF_W-1:0] tape_read_buffer; // Assembled word
		logic [BUF_W-1:0] acc; // Value for accumulator
		logic acc_load; // Accumulator strobe
		logic skip; // Skip request
		logic [3:0] winding; // Winding driver inputs
	} ptrc_state_type;

	ptrc_state_type st; // Current state
	ptrc_state_type next_st; // Next state
	ptrc_fifo_if #(.WIDTH(ENTRY_W)) lines (); // Line path
	logic run_level; // Reader may move tape
	logic select_cmd; // Select command pulse
	logic read_cmd; // Clear-OR or read-buffer
	logic tick; // Step clock tick
	logic motor_index_pulse; // Phase advance
	logic between_lines_count; // Phases differ after step
	logic gate_line_enable; // Line may enter buffer
	logic next_a; // Advanced phase a
	logic next_b; // Advanced phase b
	logic last_line; // Line completes the word
	logic [SLOT_W-1:0] slot; // Destination of this line
	logic [LINE_W-1:0] pop_line; // Drained line bits
	logic [SLOT_W-1:0] pop_slot; // Drained line slot

	// Buffer between sensing and assembly; stalls the motor when full
	ptrc_line_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(LINE_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.port(lines.store)
	);

	assign lines.push_valid = st.push_valid;
	assign lines.push_data = st.push_data;
	// Drain stalls while the finished word waits to be read
	assign lines.pop_ready = !st.line_done_flag && !select_cmd;
	assign lines.flush = select_cmd;
	assign pop_line = lines.pop_data[LINE_W-1:0];
	assign pop_slot = lines.pop_data[ENTRY_W-1:LINE_W];

	// Instruction decode and run level
	always_comb begin
		select_cmd = third_exec_pulse_in && device_select_in
			&& instr_bits_in[IB_SELECT];
		read_cmd = second_exec_pulse_in && device_select_in
			&& instr_bits_in[IB_READ];
		// Manual feed runs the motor even when not selected
		run_level = (st.run_flipflop && !st.end_of_tape_ff)
			|| manual_feed_in;
		tick = (st.seq == PTRC_STEP) && (st.tick_cnt == '0);
		// Index withheld while the FIFO has no room
		motor_index_pulse = tick && run_level
			&& lines.push_ready;
		// Gray step 00,10,11,01: a takes not b, b takes a
		next_a = !st.phase_bit_b;
		next_b = st.phase_bit_a;
		// Count one cycle after the step, with the tape between lines,
		// so a feed hole seen then really means torn or missing tape
		between_lines_count = st.count_due;
		// Hole 8 gates binary lines; alnum always gates
		gate_line_enable = st.sensed[LINE_W]
			|| st.alnum_mode_ff;
	end

	// Slot choice from the alnum mode and line stage flip-flops
	always_comb begin
		slot = SLOT_FIRST;
		last_line = 1'b0;
		if (st.alnum_mode_ff) begin
			slot = SLOT_ALNUM;
			last_line = 1'b1;
		end else if (st.line_stage_two) begin
			slot = SLOT_THIRD;
			last_line = 1'b1;
		end else if (st.line_stage_one) begin
			slot = SLOT_SECOND;
		end
	end

	// Next state of the whole control
	always_comb begin
		next_st = st;
		next_st.push_valid = 1'b0;
		next_st.acc_load = 1'b0;
		next_st.skip = 1'b0;

		// Sequencer: start delay, then the accelerating clock
		case (st.seq)
			PTRC_IDLE: begin
				if (run_level) begin
					next_st.seq = PTRC_START;
					next_st.dly = START_LD;
				end
			end
			PTRC_START: begin
				if (!run_level) begin
					next_st.seq = PTRC_IDLE;
				end else if (st.dly == '0) begin
					next_st.seq = PTRC_STEP;
					next_st.interval = SLOW_LD;
					next_st.tick_cnt = SLOW_LD;
				end else begin
					next_st.dly = st.dly - 1'b1;
				end
			end
			PTRC_STEP: begin
				if (!tick) begin
					next_st.tick_cnt = st.tick_cnt - 1'b1;
				end else if (!run_level) begin
					// Stop on the tick after run drops
					next_st.seq = PTRC_IDLE;
					next_st.motor_power_ff = 1'b0;
				end else begin
					// Shrink toward full speed, never below it
					if (st.interval > FAST_LD + ACCEL_DEC) begin
						next_st.interval = st.interval - ACCEL_DEC;
					end else begin
						next_st.interval = FAST_LD;
					end
					next_st.tick_cnt = next_st.interval;
				end
			end
			default: begin
				next_st.seq = PTRC_IDLE;
			end
		endcase

		// Motor stepping on each index pulse; a step to unequal
		// phases raises the count for the next cycle
		next_st.count_due = motor_index_pulse
			&& (next_a != next_b);
		if (motor_index_pulse) begin
			next_st.motor_power_ff = 1'b1;
			next_st.phase_bit_a = next_a;
			next_st.phase_bit_b = next_b;
		end

		// A character over the sensors while phases agree
		if (st.phase_bit_a == st.phase_bit_b) begin
			next_st.sensed = hole_in;
		end

		// Count pulse: tear check and line capture
		if (between_lines_count) begin
			if (feed_hole_in) begin
				next_st.end_of_tape_ff = 1'b1;
				next_st.run_flipflop = 1'b0;
			end else if (gate_line_enable && st.run_flipflop
				&& !st.line_done_flag) begin
				next_st.push_valid = 1'b1;
				next_st.push_data = {slot, st.sensed};
				if (last_line) begin
					// Stop taking lines once the word is whole
					next_st.run_flipflop = 1'b0;
				end else if (st.line_stage_one) begin
					next_st.line_stage_two = 1'b1;
				end
				next_st.line_stage_one = 1'b1;
			end
		end

		// Clear-OR or read-buffer: flag and stages drop
		if (read_cmd) begin
			next_st.line_done_flag = 1'b0;
			next_st.line_stage_one = 1'b0;
			next_st.line_stage_two = 1'b0;
			next_st.acc_load = 1'b1;
			if (instr_bits_in[IB_CLR_AC]) begin
				next_st.acc = st.tape_read_buffer;
			end else begin
				next_st.acc = accumulator_in
					| st.tape_read_buffer;
			end
		end

		// Skip test on the first execute pulse
		if (first_exec_pulse_in && device_select_in
			&& instr_bits_in[IB_SKIP]) begin
			next_st.skip = st.line_done_flag;
		end

		// Select clears the flag, stages, buffer and end of tape, and starts the reader
		if (select_cmd) begin
			next_st.line_done_flag = 1'b0;
			next_st.line_stage_one = 1'b0;
			next_st.line_stage_two = 1'b0;
			next_st.tape_read_buffer = '0;
			next_st.run_flipflop = 1'b1;
			next_st.end_of_tape_ff = 1'b0;
			next_st.push_valid = 1'b0;
			// Mode bit low picks alnum; high keeps it clear
			next_st.alnum_mode_ff =
				!instr_bits_in[IB_ALNUM_N];
		end

		// Drain one line into its buffer positions
		if (lines.pop_valid && lines.pop_ready) begin
			case (pop_slot)
				SLOT_FIRST: begin
					next_st.tape_read_buffer[SEG_FIRST_LO +: CHAR_W] =
						pop_line[CHAR_W-1:0];
				end
				SLOT_SECOND: begin
					next_st.tape_read_buffer[SEG_SECOND_LO +: CHAR_W] =
						pop_line[CHAR_W-1:0];
				end
				SLOT_THIRD: begin
					next_st.tape_read_buffer[SEG_THIRD_LO +: CHAR_W] =
						pop_line[CHAR_W-1:0];
					// Set wins over a clear in the same cycle
					next_st.line_done_flag = 1'b1;
				end
				SLOT_ALNUM: begin
					next_st.tape_read_buffer[SEG_ALNUM_LO +: LINE_W] =
						pop_line;
					next_st.line_done_flag = 1'b1;
				end
				default: begin
					next_st.line_done_flag = st.line_done_flag;
				end
			endcase
		end

		// Two windings at a time, only while powered
		next_st.winding = {4{next_st.motor_power_ff}} & {
			next_st.phase_bit_b, !next_st.phase_bit_b,
			next_st.phase_bit_a, !next_st.phase_bit_a};
	end

	// State register; reset leaves the motor idle and unpowered
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state, except run level, which also takes manual feed directly
	assign accumulator_out = st.acc;
	assign acc_load_out = st.acc_load;
	assign skip_request_out = st.skip;
	assign interrupt_request_out =
		st.line_done_flag || st.end_of_tape_ff;
	assign line_done_flag_out = st.line_done_flag;
	assign end_of_tape_out = st.end_of_tape_ff;
	assign run_level_out = run_level;
	assign step_clock_enable_out = (st.seq == PTRC_STEP);
	assign phase_bit_a_out = st.phase_bit_a;
	assign phase_bit_b_out = st.phase_bit_b;
	assign motor_power_out = st.motor_power_ff;
	assign winding_drive_out = st.winding;
endmodule
`default_nettype wire

// *** tb/ptrc_properties.sv ***
/*
 Port checker for the paper tape reader control.
 Assumes one clock and async active-low reset; bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module ptrc_properties
	import ptrc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic device_select_in,
	input wire logic [IB_W-1:0] instr_bits_in,
	input wire logic first_exec_pulse_in,
	input wire logic second_exec_pulse_in,
	input wire logic third_exec_pulse_in,
	input wire logic feed_hole_in,
	input wire logic manual_feed_in,
	input wire logic acc_load_out,
	input wire logic skip_request_out,
	input wire logic interrupt_request_out,
	input wire logic line_done_flag_out,
	input wire logic end_of_tape_out,
	input wire logic run_level_out,
	input wire logic phase_bit_a_out,
	input wire logic phase_bit_b_out,
	input wire logic motor_power_out,
	input wire logic [3:0] winding_drive_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	// Motor phase pair, a in the high bit
	wire logic [1:0] ph = {phase_bit_a_out, phase_bit_b_out};
	// Select command as seen on the third period
	sequence sel_cmd;
		third_exec_pulse_in && device_select_in && instr_bits_in[IB_SELECT];
	endsequence
	// Any phase move counts as an index step
	sequence phase_move;
		ph != $past(ph);
	endsequence
	gray_step_a:
	assert property (phase_move |-> {$past(ph), ph} inside
		{4'h2, 4'hb, 4'hd, 4'h4}) else $error("phase order broken");
	step_power_a:
	assert property (phase_move |-> motor_power_out)
		else $error("phase moved unpowered");
	wind_pair_a:
	assert property ($countones(winding_drive_out) ==
		(motor_power_out ? 2 : 0)) else $error("winding count");
	run_lvl_a:
	assert property (end_of_tape_out && !manual_feed_in |-> !run_level_out)
		else $error("run level with end of tape");
	run_cause_a:
	assert property ($rose(run_level_out) && !manual_feed_in |->
		$past(third_exec_pulse_in) || $past(third_exec_pulse_in, 2))
		else $error("run started off third period");
	sel_clear_a:
	assert property (sel_cmd |-> ##[1:2] !line_done_flag_out && run_level_out)
		else $error("select did not clear and run");
	skip_flag_a:
	assert property (skip_request_out |->
		($past(line_done_flag_out) || $past(line_done_flag_out, 2)) &&
		($past(first_exec_pulse_in) || $past(first_exec_pulse_in, 2)))
		else $error("skip without flag");
	load_cause_a:
	assert property (acc_load_out |->
		$past(second_exec_pulse_in) || $past(second_exec_pulse_in, 2))
		else $error("load off second period");
	irq_src_a:
	assert property (interrupt_request_out ==
		(line_done_flag_out || end_of_tape_out)) else $error("irq source");
	eot_cause_a:
	assert property ($rose(end_of_tape_out) |-> ph[1] != ph[0] &&
		($past(feed_hole_in) || $past(feed_hole_in, 2)))
		else $error("end of tape without feed hole");
endmodule
bind ptrc_reader_ctrl ptrc_properties chk (.*);
`default_nettype wire

// *** tb/ptrc_tape_model.sv ***
/*
 Tape mechanism model: lines move past the sensors with phases.
 Assumes the bench fills tape and len; positions only grow.
*/
`timescale 1ns/100ps
`default_nettype none
module ptrc_tape_model
	import ptrc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic phase_bit_a_in,
	input wire logic phase_bit_b_in,
	output logic [LINE_W:1] hole_out,
	output logic feed_hole_out
);
	logic [LINE_W:1] tape [0:255]; // Punched lines
	int len = 0; // Tape ends before this line
	int pos = 0; // Line over or just past the sensors
	logic [1:0] ph_q = 2'h0; // Phase seen last edge
	wire logic over = phase_bit_a_in == phase_bit_b_in;
	// Each return to equal phases brings the next line in
	always @(posedge ref_clk_in) begin
		ph_q <= {phase_bit_a_in, phase_bit_b_in};
		if (ph_q != {phase_bit_a_in, phase_bit_b_in} && over) begin
			pos <= pos + 1;
		end
	end
	// Past the end light reaches every cell, feed included
	always_comb begin
		if (pos >= len) begin
			hole_out = 8'hff;
			feed_hole_out = 1'b1;
		end else if (over) begin
			hole_out = tape[pos];
			feed_hole_out = 1'b1;
		end else begin
			// Between lines the tape shades all cells
			hole_out = 8'h00;
			feed_hole_out = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 Bench for the reader control: instruction tasks and tape runs.
 Assumes the tape model and checker sit beside the design.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("unexpected at %0t got %h exp %h", $time, g, e); \
	end \
end
module tb
	import ptrc_pkg::*;
;
	logic ref_clk_in = 0, rstn_in = 0, device_select_in = 0;
	logic [IB_W-1:0] instr_bits_in = 6'h00;
	logic first_exec_pulse_in = 0, second_exec_pulse_in = 0;
	logic third_exec_pulse_in = 0, manual_feed_in = 0;
	logic [BUF_W-1:0] accumulator_in = 18'h00000, accumulator_out;
	logic [LINE_W:1] hole_in;
	logic feed_hole_in, acc_load_out, skip_request_out;
	logic interrupt_request_out, line_done_flag_out, end_of_tape_out;
	logic run_level_out, step_clock_enable_out, motor_power_out;
	logic phase_bit_a_out, phase_bit_b_out;
	logic [3:0] winding_drive_out;
	int err_total = 0, tests_run = 0, b = 0, p0 = 0;
	// Short step counts keep the run brief
	ptrc_reader_ctrl #(.SLOW_CYC(50), .FAST_CYC(17), .ACCEL_N(4)) DUT (.*);
	ptrc_tape_model tm (.ref_clk_in(ref_clk_in),
		.phase_bit_a_in(phase_bit_a_out), .phase_bit_b_in(phase_bit_b_out),
		.hole_out(hole_in), .feed_hole_out(feed_hole_in));
	always #50 ref_clk_in = ~ref_clk_in;
	task automatic report_and_stop;
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// One instruction, its bits held through the chosen period
	task automatic io_transfer_instr(input int p, input logic [5:0] c,
		input logic [17:0] a);
		@(posedge ref_clk_in) #1;
		device_select_in = 1'b1;
		instr_bits_in = c;
		accumulator_in = a;
		first_exec_pulse_in = p == 1;
		second_exec_pulse_in = p == 2;
		third_exec_pulse_in = p == 3;
		@(posedge ref_clk_in) #1;
		device_select_in = 1'b0;
		{first_exec_pulse_in, second_exec_pulse_in} = 2'h0;
		third_exec_pulse_in = 1'b0;
	endtask
	// Buffer read; c set clears the accumulator first
	task automatic rd(input logic c, input logic [17:0] a, x);
		int n;
		n = 0;
		io_transfer_instr(2, c ? 6'h0a : 6'h02, a);
		while (acc_load_out !== 1'b1 && n < 4) begin
			@(posedge ref_clk_in) #1;
			n++;
		end
		if (acc_load_out !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		`CHK(acc_load_out, 1'b1)
		`CHK(accumulator_out, x)
	endtask
	task automatic skip_chk(input logic x);
		logic s;
		io_transfer_instr(1, 6'h01, 18'h00000);
		s = skip_request_out;
		@(posedge ref_clk_in) #1;
		s = s | skip_request_out;
		`CHK(s, x)
	endtask
	// Four lines from w, then fill; line b is the next over the cells
	task automatic load(input logic [31:0] w, input logic [7:0] f);
		b = tm.pos + (tm.over ? 0 : 1);
		for (int i = 0; i < 40; i++) begin
			tm.tape[b + i] = i < 4 ? w[31 - 8 * i -: 8] : f;
		end
		tm.len = b + 40;
	endtask
	// Bounded wait on flag or end of tape
	task automatic wait_hi(input int lim);
		for (int i = 0; i < lim && line_done_flag_out !== 1'b1 &&
			end_of_tape_out !== 1'b1; i++) begin
			@(posedge ref_clk_in) #1;
		end
		// A wait that runs out ends the run as a failure
		if (line_done_flag_out !== 1'b1 && end_of_tape_out !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
	endtask
	initial begin
		repeat (100000) @(posedge ref_clk_in);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge ref_clk_in);
		#1 rstn_in = 1'b1;
		`CHK({line_done_flag_out, run_level_out, motor_power_out}, 3'h0)
		`CHK({phase_bit_a_out, phase_bit_b_out, winding_drive_out}, 6'h00)
		// Select bit on the wrong period does nothing
		io_transfer_instr(1, 6'h24, 18'h00000);
		repeat (3) @(posedge ref_clk_in) #1;
		`CHK(run_level_out, 1'b0)
		// Binary word: blank leader, channel 7 punched on each data line
		load(32'h00e5dafc, 8'h00);
		io_transfer_instr(3, 6'h24, 18'h00000);
		@(posedge ref_clk_in) #1;
		`CHK({run_level_out, line_done_flag_out, step_clock_enable_out}, 3'h4)
		wait_hi(3000);
		`CHK(line_done_flag_out, 1'b1)
		`CHK({step_clock_enable_out, motor_power_out}, 2'h3)
		`CHK($countones(winding_drive_out), 2)
		`CHK(tm.pos, b + 3)
		`CHK(interrupt_request_out, 1'b1)
		skip_chk(1'b1);
		rd(1'b0, 18'h00301, 18'h257bd);
		`CHK(line_done_flag_out, 1'b0)
		rd(1'b1, 18'h3ffff, 18'h256bc);
		skip_chk(1'b0);
		// One alnum line, channel 7 punched and channel 8 blank
		load(32'h4b000000, 8'h00);
		io_transfer_instr(3, 6'h04, 18'h00000);
		wait_hi(3000);
		`CHK(tm.pos, b)
		rd(1'b1, 18'h00000, 18'h0004b);
		// Feed over fully punched tape reads nothing
		load(32'hffffffff, 8'hff);
		p0 = tm.pos;
		manual_feed_in = 1'b1;
		#1 `CHK(run_level_out, 1'b1)
		repeat (600) @(posedge ref_clk_in);
		#1 manual_feed_in = 1'b0;
		repeat (200) @(posedge ref_clk_in);
		`CHK(tm.pos > p0, 1'b1)
		`CHK(line_done_flag_out, 1'b0)
		rd(1'b1, 18'h00000, 18'h0004b);
		// Empty reader: light through the feed cell between lines
		tm.len = tm.pos;
		io_transfer_instr(3, 6'h24, 18'h00000);
		wait_hi(3000);
		`CHK(end_of_tape_out, 1'b1)
		`CHK({run_level_out, interrupt_request_out}, 2'h1)
		report_and_stop();
	end
endmodule
`default_nettype wire
